/* File: shared/serdes_defs.vh */
// constants for the ten-bit serializer and deserializer link
// What this block does
// - serializer latches ten data bits on the selected word clock edge
// - sync request held six word clocks sends 1026 sync words
// - each word framed by a high start bit and low stop bit
// - twelve bits shifted per word, twelve times the word rate
// - data words sent only with driver enabled, powered, no sync request
// - driver enable low tristates both serial output lines
// - driver enable high again resumes the unchanged prior state
// - deserializer drives lock low once synchronised; outputs invalid otherwise
// - received word presented with recovered clock in selected polarity
// - deserializer powers down on both inputs low; serializer on power-down low
// - power-down stops the engine and tristates outputs until released
// - serializer needs 1026 word clocks of initialisation after power-down
// - deserializer holds lock high after power-down until it relocks
// - receive enable low tristates received word and recovered clock
// - lock output stays driven while receive outputs are disabled, unless power-down is also low
// - received word and recovered clock tristate while not locked
// - recovered clock runs only while locked and enabled
// - undriven serial input reads high and forces lock indication high
// - sync word is six ones then six zeros
// - lock after four framed words in place; unlock after four misses
// - serializer edge select low falling edge, high rising edge
// - deserializer edge select low falling edge, high rising edge
`ifndef SERDES_DEFS_VH
`define SERDES_DEFS_VH
`define FRAME_BITS 12
`define BIT_STEP 17'h0000c
`define SYNC_HOLD_WORDS 3'h6
`define SYNC_WORDS 11'h402
`define INIT_WORDS 11'h402
`define LOCK_HITS 3'h4
`define LOCK_MISSES 3'h4
`define SYNC_PATTERN 12'hfc0
`define START_BIT 1'b1
`define STOP_BIT 1'b0
`define RCLK_HIGH_POS 4'h6
`define LAST_POS 4'hb
`define CTRL_OFS 12'h000
`define STAT_OFS 12'h004
`define WORD_OFS 12'h008
`define CTRL_RST 2'h0
`define CTRL_SW_SYNC 0
`define CTRL_RELOCK 1
`define STAT_TXST_LSB 0
`define STAT_LOCK_BIT 4
`define STAT_HITS_LSB 5
`define STAT_MISS_LSB 8
`define STAT_CNT_LSB 11
`endif

/* File: logic/pin_sync.v */
// two-flop synchroniser for a group of asynchronous pins
module pin_sync #(
   parameter WIDTH = 1
) (
   input wire pclk,
   input wire presetn,
   input wire [WIDTH-1:0] d,
   output wire [WIDTH-1:0] q
);
   reg [WIDTH-1:0] meta_r;
   reg [WIDTH-1:0] q_r;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_r <= {WIDTH{1'b0}};
         q_r <= {WIDTH{1'b0}};
      end
      else
      begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end

   assign q = q_r;
endmodule // pin_sync

/* File: logic/bit_timer.v */
// measures a sampled clock period and divides it into twelve bit ticks
`include "serdes_defs.vh"
module bit_timer (
   input wire pclk,
   input wire presetn,
   input wire ref_s,
   input wire align,
   input wire align_half,
   output wire ref_rise,
   output wire ref_fall,
   output wire bit_tick
);
   reg ref_d_r;
   reg [15:0] cnt_r;
   reg [15:0] period_r;
   reg [15:0] acc_r;
   reg tick_r;
   wire [16:0] sum;
   wire [16:0] rem;
   wire [16:0] step;

   assign ref_rise = ref_s & ~ref_d_r;
   assign ref_fall = ~ref_s & ref_d_r;
   assign sum = {1'b0, acc_r} + `BIT_STEP;
   assign rem = sum - {1'b0, period_r};
   assign bit_tick = tick_r;
   assign step = `BIT_STEP;

   // fractional accumulator: exactly twelve ticks per measured period
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ref_d_r <= 1'b0;
         cnt_r <= 16'h0000;
         period_r <= 16'h0000;
         acc_r <= 16'h0000;
         tick_r <= 1'b0;
      end
      else
      begin
         ref_d_r <= ref_s;
         if (ref_rise)
         begin
            period_r <= cnt_r + 16'h0001;
            cnt_r <= 16'h0000;
         end
         else if (cnt_r != 16'hffff)
            cnt_r <= cnt_r + 16'h0001;
         // the align cycle counts as one step, else every bit lands late
         // and the stop bit is cut; a receiver samples at once unless a
         // tick is already being taken in this cycle
         if (align)
         begin
            acc_r <= align_half ? {1'b0, period_r[15:1]} : step[15:0];
            tick_r <= align_half & ~tick_r;
         end
         else if (period_r != 16'h0000 && sum >= {1'b0, period_r})
         begin
            acc_r <= rem[15:0];
            tick_r <= 1'b1;
         end
         else
         begin
            acc_r <= sum[15:0];
            tick_r <= 1'b0;
         end
      end
   end
endmodule // bit_timer

/* File: logic/ten_bit_serdes_link.v */
// ten-bit serializer and deserializer with an apb status port
`include "serdes_defs.vh"
module ten_bit_serdes_link (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire transmit_word_clock,
   input wire tx_capture_edge_select,
   input wire [9:0] tx_parallel_word,
   input wire sync_request_a,
   input wire sync_request_b,
   input wire serial_driver_enable,
   input wire tx_power_down_n,
   output reg tx_serial_p,
   output reg tx_serial_n,
   output reg tx_serial_oe,
   input wire receiver_reference_clock,
   input wire rx_serial,
   input wire rx_serial_driven,
   input wire rx_output_enable,
   input wire rx_strobe_edge_select,
   input wire rx_power_down_n,
   output reg [9:0] rx_parallel_word,
   output reg rx_word_oe,
   output reg recovered_clock,
   output reg recovered_clock_oe,
   output reg lock_n,
   output reg lock_n_oe
);
   localparam TX_PD = 4'b0001;
   localparam TX_INIT = 4'b0010;
   localparam TX_SYNC = 4'b0100;
   localparam TX_DATA = 4'b1000;

   wire [21:0] pins_s;
   wire transmit_word_clock_s;
   wire tedge_s;
   wire [9:0] din_s;
   wire sync_a_s;
   wire sync_b_s;
   wire den_s;
   wire tpd_n_s;
   wire receiver_reference_clock_s;
   wire rxd_s;
   wire rxdrv_s;
   wire ren_s;
   wire redge_s;
   wire rpd_n_s;

   pin_sync #(.WIDTH(22)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({transmit_word_clock, tx_capture_edge_select, tx_parallel_word,
         sync_request_a, sync_request_b, serial_driver_enable,
         tx_power_down_n, receiver_reference_clock, rx_serial,
         rx_serial_driven, rx_output_enable, rx_strobe_edge_select,
         rx_power_down_n}),
      .q(pins_s)
   );

   assign {transmit_word_clock_s, tedge_s, din_s, sync_a_s, sync_b_s, den_s, tpd_n_s,
      receiver_reference_clock_s, rxd_s, rxdrv_s, ren_s, redge_s, rpd_n_s} = pins_s;

   reg [1:0] ctrl_r;
   reg [3:0] tx_state_r;
   reg [10:0] tx_cnt_r;
   reg [2:0] hold_r;
   reg [9:0] tx_word_r;
   reg cap_d_r;
   reg [11:0] shift_r;
   reg [11:0] frame;
   wire transmit_word_clock_rise;
   wire transmit_word_clock_fall;
   wire tx_tick;
   wire cap;
   wire sync_req;
   wire sync_long;
   integer i;
   integer j;

   assign cap = tedge_s ? transmit_word_clock_rise : transmit_word_clock_fall;
   assign sync_req = sync_a_s | sync_b_s | ctrl_r[`CTRL_SW_SYNC];
   assign sync_long = (hold_r == `SYNC_HOLD_WORDS);

   bit_timer u_tx_timer (
      .pclk(pclk),
      .presetn(presetn),
      .ref_s(transmit_word_clock_s),
      .align(cap_d_r),
      .align_half(1'b0),
      .ref_rise(transmit_word_clock_rise),
      .ref_fall(transmit_word_clock_fall),
      .bit_tick(tx_tick)
   );

   // start bit leads, data bit zero next, stop bit last
   always @*
   begin
      frame = 12'h000;
      frame[`FRAME_BITS-1] = `START_BIT;
      frame[0] = `STOP_BIT;
      for (i = 0; i < 10; i = i + 1)
         frame[10-i] = tx_word_r[i];
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_state_r <= TX_PD;
         tx_cnt_r <= 11'h000;
         hold_r <= 3'h0;
         tx_word_r <= 10'h000;
         cap_d_r <= 1'b0;
         shift_r <= 12'h000;
      end
      else
      begin
         cap_d_r <= cap;
         if (cap)
            tx_word_r <= din_s;
         // request width measured in word clocks, saturating at the limit
         if (transmit_word_clock_rise)
         begin
            if (!sync_req)
               hold_r <= 3'h0;
            else if (!sync_long)
               hold_r <= hold_r + 3'h1;
         end
         if (cap_d_r)
         begin
            if (tx_state_r == TX_DATA && !sync_req)
               shift_r <= frame;
            else
               shift_r <= `SYNC_PATTERN;
         end
         else if (tx_tick)
            shift_r <= {shift_r[10:0], 1'b0};
         // the state machine ignores the driver enable so that
         // switching the driver back on finds the sequence unchanged
         if (!tpd_n_s)
         begin
            tx_state_r <= TX_PD;
            tx_cnt_r <= 11'h000;
         end
         else
         begin
            case (tx_state_r)
               TX_PD:
               begin
                  tx_state_r <= TX_INIT;
                  tx_cnt_r <= 11'h000;
               end
               TX_INIT:
               begin
                  if (cap)
                  begin
                     if (tx_cnt_r == `INIT_WORDS - 11'h001)
                     begin
                        tx_state_r <= TX_DATA;
                        tx_cnt_r <= 11'h000;
                     end
                     else
                        tx_cnt_r <= tx_cnt_r + 11'h001;
                  end
               end
               TX_DATA:
               begin
                  if (sync_long)
                  begin
                     tx_state_r <= TX_SYNC;
                     tx_cnt_r <= 11'h000;
                  end
               end
               TX_SYNC:
               begin
                  if (cap)
                  begin
                     if (tx_cnt_r == `SYNC_WORDS - 11'h001)
                     begin
                        tx_cnt_r <= 11'h000;
                        if (!sync_long)
                           tx_state_r <= TX_DATA;
                     end
                     else
                        tx_cnt_r <= tx_cnt_r + 11'h001;
                  end
               end
               default:
               begin
                  tx_state_r <= TX_PD;
                  tx_cnt_r <= 11'h000;
               end
            endcase
         end
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_serial_p <= 1'b0;
         tx_serial_n <= 1'b1;
         tx_serial_oe <= 1'b0;
      end
      else
      begin
         tx_serial_p <= shift_r[11];
         tx_serial_n <= ~shift_r[11];
         // driver stays off while the engine initialises
         tx_serial_oe <= den_s &
            (tx_state_r == TX_DATA || tx_state_r == TX_SYNC);
      end
   end

   reg rxb_d_r;
   reg [11:0] win_r;
   reg [3:0] pos_r;
   reg [2:0] hits_r;
   reg [2:0] miss_r;
   reg locked_r;
   reg [9:0] rx_word_r;
   wire rx_pd;
   wire rx_bit;
   wire rx_tick;
   wire [11:0] win_nxt;
   wire frame_ok;
   wire rclk_base;

   assign rx_pd = ~rpd_n_s & ~ren_s;
   assign rx_bit = rxdrv_s ? rxd_s : 1'b1;
   assign win_nxt = {win_r[10:0], rx_bit};
   assign frame_ok = win_nxt[11] == `START_BIT && win_nxt[0] == `STOP_BIT;
   assign rclk_base = (pos_r >= `RCLK_HIGH_POS);

   // every line transition recentres the sampling point mid-bit
   bit_timer u_rx_timer (
      .pclk(pclk),
      .presetn(presetn),
      .ref_s(receiver_reference_clock_s),
      .align(rx_bit != rxb_d_r),
      .align_half(1'b1),
      .ref_rise(),
      .ref_fall(),
      .bit_tick(rx_tick)
   );

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rxb_d_r <= 1'b1;
         win_r <= 12'h000;
         pos_r <= 4'h0;
         hits_r <= 3'h0;
         miss_r <= 3'h0;
         locked_r <= 1'b0;
         rx_word_r <= 10'h000;
      end
      else
      begin
         rxb_d_r <= rx_bit;
         if (rx_pd || !rxdrv_s || ctrl_r[`CTRL_RELOCK])
         begin
            locked_r <= 1'b0;
            hits_r <= 3'h0;
            miss_r <= 3'h0;
            pos_r <= 4'h0;
         end
         else if (rx_tick)
         begin
            win_r <= win_nxt;
            if (pos_r != `LAST_POS)
               pos_r <= pos_r + 4'h1;
            else if (frame_ok)
            begin
               pos_r <= 4'h0;
               miss_r <= 3'h0;
               for (j = 0; j < 10; j = j + 1)
                  rx_word_r[j] <= win_nxt[10-j];
               if (!locked_r)
               begin
                  if (hits_r == `LOCK_HITS - 3'h1)
                     locked_r <= 1'b1;
                  hits_r <= hits_r + 3'h1;
               end
            end
            else
            begin
               hits_r <= 3'h0;
               if (locked_r)
               begin
                  pos_r <= 4'h0;
                  if (miss_r == `LOCK_MISSES - 3'h1)
                  begin
                     locked_r <= 1'b0;
                     miss_r <= 3'h0;
                  end
                  else
                     miss_r <= miss_r + 3'h1;
               end
               // hunting: slip one bit and test the next boundary
               else
                  pos_r <= `LAST_POS;
            end
         end
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_parallel_word <= 10'h000;
         rx_word_oe <= 1'b0;
         recovered_clock <= 1'b0;
         recovered_clock_oe <= 1'b0;
         lock_n <= 1'b1;
         lock_n_oe <= 1'b0;
      end
      else
      begin
         rx_parallel_word <= rx_word_r;
         lock_n <= ~locked_r;
         lock_n_oe <= ~rx_pd;
         rx_word_oe <= locked_r & ren_s & ~rx_pd;
         recovered_clock_oe <= locked_r & ren_s & ~rx_pd;
         // word changes at pos 0, so the mid-word edge sees stable data
         if (locked_r && ren_s && !rx_pd)
            recovered_clock <= redge_s ? rclk_base : ~rclk_base;
         else
            recovered_clock <= 1'b0;
      end
   end

   reg [31:0] stat;

   always @*
   begin
      stat = 32'h0000_0000;
      stat[`STAT_TXST_LSB +: 4] = tx_state_r;
      stat[`STAT_LOCK_BIT] = locked_r;
      stat[`STAT_HITS_LSB +: 3] = hits_r;
      stat[`STAT_MISS_LSB +: 3] = miss_r;
      stat[`STAT_CNT_LSB +: 11] = tx_cnt_r;
   end

   // no wait state: read data is registered in the setup cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r <= `CTRL_RST;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel & ~penable;
         if (psel && !penable)
         begin
            pslverr <= 1'b0;
            case (paddr)
               `CTRL_OFS: prdata <= {30'h0000_0000, ctrl_r};
               `STAT_OFS: prdata <= stat;
               `WORD_OFS: prdata <= {22'h00_0000, rx_word_r};
               default:
               begin
                  prdata <= 32'h0000_0000;
                  pslverr <= 1'b1;
               end
            endcase
         end
         if (psel && penable && pready && pwrite && paddr == `CTRL_OFS)
            ctrl_r <= pwdata[1:0];
      end
   end
endmodule // ten_bit_serdes_link

/* File: tb/serdes_link_assertions.sv */
// port-level checker for the ten-bit serdes link
module serdes_link_assertions (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire serial_driver_enable,
   input wire tx_power_down_n,
   input wire tx_serial_p,
   input wire tx_serial_n,
   input wire tx_serial_oe,
   input wire rx_serial_driven,
   input wire rx_output_enable,
   input wire rx_power_down_n,
   input wire rx_word_oe,
   input wire recovered_clock,
   input wire recovered_clock_oe,
   input wire lock_n,
   input wire lock_n_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // pins pass two flops, so five cycles of a level give the output time
   a_apb_ready: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   a_err_data: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("error read returned data");
   a_den_tri: assert property (
      (!serial_driver_enable)[*5] |-> !tx_serial_oe)
      else $error("serial line driven while disabled");
   a_tx_pd_tri: assert property (
      (!tx_power_down_n)[*5] |-> !tx_serial_oe)
      else $error("serial line driven in power down");
   a_init_quiet: assert property (
      $rose(tx_power_down_n) |-> (!tx_serial_oe)[*8])
      else $error("serial line driven during init");
   a_tx_diff: assert property (
      tx_serial_oe |-> tx_serial_n != tx_serial_p)
      else $error("serial pair not complementary");
   a_rx_ren_tri: assert property (
      (!rx_output_enable)[*5] |-> !rx_word_oe && !recovered_clock_oe)
      else $error("receive outputs driven while disabled");
   a_unlock_tri: assert property (
      lock_n[*2] |-> !rx_word_oe && !recovered_clock_oe)
      else $error("receive outputs driven while unlocked");
   a_lock_kept: assert property (
      (rx_power_down_n || rx_output_enable)[*5] |-> lock_n_oe)
      else $error("lock output released while powered");
   a_rx_pd: assert property (
      (!rx_power_down_n && !rx_output_enable)[*5] |-> !lock_n_oe && lock_n)
      else $error("receiver not powered down");
   a_failsafe: assert property (
      (!rx_serial_driven)[*5] |-> lock_n)
      else $error("locked with undriven input");
   a_rclk_idle: assert property (
      (!recovered_clock_oe)[*2] |-> !recovered_clock)
      else $error("recovered clock runs while off");
   c_lock: cover property ($fell(lock_n));
   c_tx_on: cover property ($rose(tx_serial_oe));
   c_apb_err: cover property (pready && pslverr);
endmodule // serdes_link_assertions

bind ten_bit_serdes_link serdes_link_assertions i_chk (.pclk, .presetn,
   .psel, .penable, .prdata, .pready, .pslverr, .serial_driver_enable,
   .tx_power_down_n, .tx_serial_p, .tx_serial_n, .tx_serial_oe,
   .rx_serial_driven, .rx_output_enable, .rx_power_down_n, .rx_word_oe,
   .recovered_clock, .recovered_clock_oe, .lock_n, .lock_n_oe);

/* File: tb/far_serializer_model.sv */
// far-end serializer model driving the receive serial line
module far_serializer_model (
   input wire logic enable,
   input wire logic bad_stop,
   input wire logic [9:0] word,
   output logic line,
   output logic line_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam real bit_ns = 160.0 / 12;
   initial
   begin
      line = 1'b0;
      line_oe = 1'b0;
      forever
      begin
         line_oe = enable;
         // released line toggles so no stale level can pass for data
         line = enable ? 1'b1 : ~line;
         #(bit_ns);
         for (int i = 0; i < 10; i++)
         begin
            // a cut link releases the line at the next bit, not the next word
            line_oe = enable;
            line = line_oe ? word[i] : ~line;
            #(bit_ns);
         end
         line_oe = enable;
         line = line_oe ? bad_stop : ~line;
         #(bit_ns);
      end
   end
endmodule // far_serializer_model

/* File: tb/tb_top.sv */
// self-checking bench for the ten-bit serdes link
`include "serdes_defs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [9:0] word_a = 10'h155;
   localparam logic [9:0] word_b = 10'h0ab;
   localparam real bit_ns = 160.0 / 12;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic transmit_word_clock, tx_capture_edge_select, sync_request_a;
   logic sync_request_b, serial_driver_enable, tx_power_down_n;
   logic [9:0] tx_parallel_word, rx_parallel_word, far_word;
   logic tx_serial_p, tx_serial_n, tx_serial_oe, receiver_reference_clock;
   logic rx_serial, rx_serial_driven, rx_output_enable, rx_word_oe;
   logic rx_strobe_edge_select, rx_power_down_n, recovered_clock;
   logic recovered_clock_oe, lock_n, lock_n_oe, far_en, far_bad, twc_d;
   int errors, num_checks, half_cnt;
   ten_bit_serdes_link i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .transmit_word_clock,
      .tx_capture_edge_select, .tx_parallel_word, .sync_request_a,
      .sync_request_b, .serial_driver_enable, .tx_power_down_n,
      .tx_serial_p, .tx_serial_n, .tx_serial_oe, .receiver_reference_clock,
      .rx_serial, .rx_serial_driven, .rx_output_enable,
      .rx_strobe_edge_select, .rx_power_down_n, .rx_parallel_word,
      .rx_word_oe, .recovered_clock, .recovered_clock_oe, .lock_n,
      .lock_n_oe);
   far_serializer_model i_far (.enable(far_en), .bad_stop(far_bad),
      .word(far_word), .line(rx_serial), .line_oe(rx_serial_driven));
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial
   begin
      transmit_word_clock = 1'b0;
      #1.3;
      forever #80 transmit_word_clock = ~transmit_word_clock;
   end
   initial
   begin
      receiver_reference_clock = 1'b0;
      #3.1;
      forever #80 receiver_reference_clock = ~receiver_reference_clock;
   end
   // word_a stands around the rising word clock edge, word_b the falling
   always @(posedge pclk)
   begin
      twc_d <= transmit_word_clock;
      half_cnt <= (twc_d != transmit_word_clock) ? 0 : half_cnt + 1;
      tx_parallel_word <= (transmit_word_clock ^ (half_cnt >= 8)) ?
         word_a : word_b;
   end
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_until(input logic sel, input logic val,
      input int limit, output int n);
      n = 0;
      while ((sel ? lock_n : tx_serial_oe) !== val && n < limit)
      begin
         @(posedge pclk);
         n++;
      end
      if (n >= limit)
      begin
         errors++;
         $display("ERROR wait %b expected %b", sel, val);
         test_done();
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 16)
      begin
         @(posedge pclk);
         n++;
      end
      rd = prdata;
      err = pslverr;
      chk("apb wait", 32'h1, {31'h0, n < 16});
      if (n >= 16)
         test_done();
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   function automatic logic [11:0] frame_of(input logic [9:0] w);
      frame_of = {`START_BIT, 10'h000, `STOP_BIT};
      for (int i = 0; i < 10; i++)
         frame_of[10 - i] = w[i];
   endfunction
   // start bit found as the first rise after the capture edge: d9 is 0
   task automatic check_frame(input logic rise, input logic [11:0] exp);
      int n;
      logic [11:0] got;
      n = 0;
      if (rise)
         @(posedge transmit_word_clock);
      else
         @(negedge transmit_word_clock);
      while (tx_serial_p !== 1'b1 && n < 60)
      begin
         #1;
         n++;
      end
      #(bit_ns / 2);
      for (int k = 11; k >= 0; k--)
      begin
         got[k] = tx_serial_p;
         #(bit_ns);
      end
      chk("frame", {20'h0, exp}, {20'h0, got});
      @(posedge pclk);
   endtask
   task automatic test_regs();
      logic [31:0] rd;
      logic err;
      apb(1'b0, `CTRL_OFS, 32'h0, rd, err);
      chk("ctrl", 32'h0, rd);
      apb(1'b0, `STAT_OFS, 32'h0, rd, err);
      chk("stat", 32'h1, rd & 32'h1f);
      apb(1'b0, 12'h00c, 32'h0, rd, err);
      chk("bad rd", 32'h0, rd);
      chk("bad err", 32'h1, {31'h0, err});
      apb(1'b1, `CTRL_OFS, 32'h2, rd, err);
      apb(1'b0, `CTRL_OFS, 32'h0, rd, err);
      chk("ctrl wr", 32'h2, rd);
      apb(1'b1, `CTRL_OFS, 32'h0, rd, err);
   endtask
   task automatic test_tx();
      int n;
      tx_power_down_n <= 1'b1;
      wait_until(1'b0, 1'b1, 1100 * 32, n);
      chk("init", 32'h1, {31'h0, n >= 1020 * 32});
      repeat (64) @(posedge pclk);
      check_frame(1'b1, frame_of(word_a));
      tx_capture_edge_select <= 1'b0;
      repeat (64) @(posedge pclk);
      check_frame(1'b0, frame_of(word_b));
      serial_driver_enable <= 1'b0;
      repeat (8) @(posedge pclk);
      chk("tx oe", 32'h0, {31'h0, tx_serial_oe});
      serial_driver_enable <= 1'b1;
      repeat (64) @(posedge pclk);
      check_frame(1'b0, frame_of(word_b));
   endtask
   task automatic test_rx();
      int n;
      int edges;
      logic prev;
      far_en <= 1'b1;
      wait_until(1'b1, 1'b0, 40 * 32, n);
      chk("lock time", 32'h1, {31'h0, n >= 3 * 32});
      repeat (64) @(posedge pclk);
      chk("rx word", {22'h0, far_word}, {22'h0, rx_parallel_word});
      chk("rx oe", 32'h1, {31'h0, rx_word_oe});
      rx_strobe_edge_select <= 1'b0;
      edges = 0;
      prev = 1'b1;
      repeat (320)
      begin
         @(posedge pclk);
         edges += (recovered_clock === 1'b1 && prev === 1'b0);
         prev = recovered_clock;
      end
      chk("rclk", 32'h1, {31'h0, edges >= 9 && edges <= 11});
      rx_output_enable <= 1'b0;
      repeat (8) @(posedge pclk);
      chk("ren oe", 32'h0, {30'h0, rx_word_oe, recovered_clock_oe});
      chk("ren lock", 32'h2, {30'h0, lock_n_oe, lock_n});
      rx_output_enable <= 1'b1;
      far_bad <= 1'b1;
      wait_until(1'b1, 1'b1, 40 * 32, n);
      chk("unlock", 32'h1, {31'h0, n >= 3 * 32});
      far_bad <= 1'b0;
      wait_until(1'b1, 1'b0, 40 * 32, n);
      far_en <= 1'b0;
      wait_until(1'b1, 1'b1, 16, n);
      chk("float oe", 32'h0, {31'h0, rx_word_oe});
      far_en <= 1'b1;
      wait_until(1'b1, 1'b0, 40 * 32, n);
      rx_power_down_n <= 1'b0;
      repeat (8) @(posedge pclk);
      chk("pd ren", 32'h0, {31'h0, lock_n});
      rx_output_enable <= 1'b0;
      repeat (8) @(posedge pclk);
      chk("pd oe", 32'h0, {31'h0, lock_n_oe});
      rx_power_down_n <= 1'b1;
      rx_output_enable <= 1'b1;
      repeat (8) @(posedge pclk);
      chk("pd exit", 32'h1, {31'h0, lock_n});
      wait_until(1'b1, 1'b0, 40 * 32, n);
   endtask
   task automatic test_sync();
      logic [31:0] rd;
      logic err;
      apb(1'b1, `CTRL_OFS, 32'h1, rd, err);
      check_frame(1'b0, `SYNC_PATTERN);
      apb(1'b1, `CTRL_OFS, 32'h0, rd, err);
      sync_request_b <= 1'b1;
      repeat (8 * 32) @(posedge pclk);
      check_frame(1'b0, `SYNC_PATTERN);
      sync_request_b <= 1'b0;
   endtask
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {sync_request_a, sync_request_b, tx_power_down_n, far_en} = '0;
      {far_bad, rx_power_down_n, rx_output_enable} = 3'b011;
      {tx_capture_edge_select, serial_driver_enable} = 2'b11;
      rx_strobe_edge_select = 1'b1;
      // ones then zeros: the only low-to-high step in the stream is the
      // stop-to-start one, so hunting cannot settle on a false boundary
      far_word = 10'h007;
      tx_parallel_word = word_b;
      twc_d = 1'b0;
      half_cnt = 0;
      errors = 0;
      num_checks = 0;
      presetn = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      test_regs();
      test_tx();
      test_rx();
      test_sync();
      test_done();
   end
endmodule // tb_top
